// *** master_queue_enable_consts.vh ***
`ifndef MASTER_QUEUE_ENABLE_CONSTS_VH
`define MASTER_QUEUE_ENABLE_CONSTS_VH

// =============================================================
// register offsets
`define MQE_OFS_112_127 16'h0150
`define MQE_OFS_96_111 16'h0152
`define MQE_OFS_80_95 16'h0154
`define MQE_OFS_64_79 16'h0156
`define MQE_OFS_48_63 16'h0158
`define MQE_OFS_32_47 16'h015A
`define MQE_OFS_16_31 16'h015C
`define MQE_OFS_0_15 16'h015E

// =============================================================
// layout and reset
`define MQE_BASE_OFS 16'h0150
`define MQE_OFS_STEP 2
`define MQE_WORDS 8
`define MQE_WORD_W 16
`define MQE_QUEUES 128
`define MQE_RESET 16'h0000
`define MQE_FIELD_LSB 0

`endif

// *** queue_enable_word.v ***
`timescale 1ns/1ps
// =============================================================
// one 16-bit read/write enable word
module queue_enable_word #(
   parameter WIDTH = 16
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire wr_i,
   input wire [WIDTH-1:0] wdata_i,
   output wire [WIDTH-1:0] value_o
);
   reg [WIDTH-1:0] word_q;

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         word_q <= {WIDTH{1'b0}};
      end else if (ce_i && wr_i) begin
         word_q <= wdata_i;
      end
   end

   assign value_o = word_q;
endmodule

// *** queue_enable_decode.v ***
`timescale 1ns/1ps
`include "master_queue_enable_consts.vh"
// =============================================================
// offset to word index; word 0 maps to the highest queues
module queue_enable_decode (
   input wire [15:0] addr_i,
   output reg hit_o,
   output reg [2:0] idx_o
);
   reg [15:0] rel;

   always @* begin
      rel = addr_i - `MQE_BASE_OFS;
      hit_o = (addr_i >= `MQE_BASE_OFS) && (rel[15:4] == 12'h000)
         && (rel[0] == 1'b0);
      idx_o = rel[3:1];
   end
endmodule

// *** master_queue_enable_bank.v ***
// Notes on behaviour
// - word at 0152h holds queues 96..111
// - word at 0154h holds queues 80..95
// - word at 0156h holds queues 64..79
// - word at 0158h holds queues 48..63
// - word at 015Ah holds queues 32..47
// - set bit enables queue; clear disables
// - 0150h, 015Ch, 015Eh hold remaining queues
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "master_queue_enable_consts.vh"
module master_queue_enable_bank #(
   parameter WORD_W = 16,
   parameter WORDS = 8
) (
   input wire CLK_SYS_I,
   input wire RST_N_I,
   input wire CE_I,
   input wire [15:0] ADDR_I,
   input wire [WORD_W-1:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   output reg [WORD_W-1:0] RDATA_O,
   output wire [WORD_W*WORDS-1:0] QUEUE_ENABLE_O
);
   // =============================================================
   // address decode
   wire hit;
   wire [2:0] idx;
   wire wr_take;
   wire rd_take;
   reg [WORDS-1:0] wr_sel;
   wire [WORD_W-1:0] word_val [0:WORDS-1];

   // odd offsets and offsets outside the bank miss
   // the bank answers every read made with the enable high in the next cycle; no wait states
   queue_enable_decode u_dec (
      .addr_i(ADDR_I),
      .hit_o(hit),
      .idx_o(idx)
   );

   // =============================================================
   // word indices; lowest offset holds the top queues
   // queues 112..127
   localparam [2:0] IDX_112_127 = 3'h0;

   localparam [2:0] IDX_96_111 = 3'h1;

   localparam [2:0] IDX_80_95 = 3'h2;

   localparam [2:0] IDX_64_79 = 3'h3;

   localparam [2:0] IDX_48_63 = 3'h4;

   localparam [2:0] IDX_32_47 = 3'h5;

   localparam [2:0] IDX_16_31 = 3'h6;

   localparam [2:0] IDX_0_15 = 3'h7;

   // =============================================================
   // register offsets
   // even byte offsets, one 16-bit word each
   // queues 112..127
   localparam [15:0] OFS_112_127 = `MQE_OFS_112_127;

   localparam [15:0] OFS_96_111 = `MQE_OFS_96_111;

   localparam [15:0] OFS_80_95 = `MQE_OFS_80_95;

   localparam [15:0] OFS_64_79 = `MQE_OFS_64_79;

   localparam [15:0] OFS_48_63 = `MQE_OFS_48_63;

   localparam [15:0] OFS_32_47 = `MQE_OFS_32_47;

   localparam [15:0] OFS_16_31 = `MQE_OFS_16_31;

   localparam [15:0] OFS_0_15 = `MQE_OFS_0_15;

   // =============================================================
   // access qualification
   // odd or unmapped offsets: write dropped, read returns zero
   // the enable gates the strobes here and again in each word
   assign wr_take = CE_I && WR_I && hit;
   assign rd_take = CE_I && RD_I && hit;

   // =============================================================
   // write select by offset, one-hot over the words
   // a missed offset leaves all selects low
   always @* begin
      wr_sel = {WORDS{1'b0}};
      if (wr_take) begin
         case (ADDR_I)
            OFS_112_127: begin
               wr_sel[IDX_112_127] = 1'b1;
            end

            OFS_96_111: begin
               wr_sel[IDX_96_111] = 1'b1;
            end

            OFS_80_95: begin
               wr_sel[IDX_80_95] = 1'b1;
            end

            OFS_64_79: begin
               wr_sel[IDX_64_79] = 1'b1;
            end

            OFS_48_63: begin
               wr_sel[IDX_48_63] = 1'b1;
            end

            OFS_32_47: begin
               wr_sel[IDX_32_47] = 1'b1;
            end

            OFS_16_31: begin
               wr_sel[IDX_16_31] = 1'b1;
            end

            OFS_0_15: begin
               wr_sel[IDX_0_15] = 1'b1;
            end

            default: begin
               wr_sel = {WORDS{1'b0}};
            end
         endcase
      end
   end

   // =============================================================
   // storage, one flip-flop word per register
   // reset is not gated by the enable, so a frozen bank still clears
   // wr_sel is already qualified by the enable and the decode
   genvar g;

   generate
      for (g = 0; g < WORDS; g = g + 1) begin : g_word
         queue_enable_word #(
            .WIDTH(WORD_W)
         ) u_word (
            .clk_i(CLK_SYS_I),
            .rst_n_i(RST_N_I),
            .ce_i(CE_I),
            .wr_i(wr_sel[g]),
            .wdata_i(WDATA_I),
            .value_o(word_val[g])
         );
      end
   endgenerate

   // =============================================================
   // named views of the words
   // names by queue range, read by the read select
   wire [WORD_W-1:0] queue_enable_word_112_127;
   wire [WORD_W-1:0] queue_enable_word_96_111;
   wire [WORD_W-1:0] queue_enable_word_80_95;
   wire [WORD_W-1:0] queue_enable_word_64_79;
   wire [WORD_W-1:0] queue_enable_word_48_63;
   wire [WORD_W-1:0] queue_enable_word_32_47;
   wire [WORD_W-1:0] queue_enable_word_16_31;
   wire [WORD_W-1:0] queue_enable_word_0_15;

   assign queue_enable_word_112_127 = word_val[IDX_112_127];

   assign queue_enable_word_96_111 = word_val[IDX_96_111];

   assign queue_enable_word_80_95 = word_val[IDX_80_95];

   assign queue_enable_word_64_79 = word_val[IDX_64_79];

   assign queue_enable_word_48_63 = word_val[IDX_48_63];

   assign queue_enable_word_32_47 = word_val[IDX_32_47];

   assign queue_enable_word_16_31 = word_val[IDX_16_31];

   assign queue_enable_word_0_15 = word_val[IDX_0_15];

   // =============================================================
   // queue vector, bit n is queue n
   // word 0 sits at the lowest offset but carries the top queues
   // no extra register here: a write shows one cycle later
   genvar n;

   generate
      for (n = 0; n < WORD_W*WORDS; n = n + 1) begin : g_queue
         // WSEL walks the words from the top, BSEL the bit inside
         localparam integer WSEL = WORDS - 1 - n / WORD_W;
         localparam integer BSEL = n % WORD_W;

         assign QUEUE_ENABLE_O[n] = word_val[WSEL][BSEL];
      end
   endgenerate

   // =============================================================
   // read select by word index
   // unmapped or odd offsets give zero, never stale data
   reg [WORD_W-1:0] rdata_d;
   reg [WORD_W-1:0] rdata_q;

   always @* begin
      rdata_d = `MQE_RESET;
      if (rd_take) begin
         case (idx)
            IDX_112_127: begin
               rdata_d = queue_enable_word_112_127;
            end

            IDX_96_111: begin
               rdata_d = queue_enable_word_96_111;
            end

            IDX_80_95: begin
               rdata_d = queue_enable_word_80_95;
            end

            IDX_64_79: begin
               rdata_d = queue_enable_word_64_79;
            end

            IDX_48_63: begin
               rdata_d = queue_enable_word_48_63;
            end

            IDX_32_47: begin
               rdata_d = queue_enable_word_32_47;
            end

            IDX_16_31: begin
               rdata_d = queue_enable_word_16_31;
            end

            IDX_0_15: begin
               rdata_d = queue_enable_word_0_15;
            end

            default: begin
               rdata_d = `MQE_RESET;
            end
         endcase
      end
   end

   // =============================================================
   // read data register, one cycle after the strobe
   // with the enable low the last value is held
   // reset clears the read data along with the words
   always @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         rdata_q <= `MQE_RESET;
      end else if (CE_I) begin
         rdata_q <= rdata_d;
      end
   end

   // data output straight from the read register
   always @* begin
      RDATA_O = rdata_q;
   end
endmodule

// *** mqe_chk_assertions.sv ***
`timescale 1ns/1ps
module mqe_chk(input wire CLK_SYS_I,
RST_N_I,
CE_I,
WR_I,
RD_I,
input wire [15:0] ADDR_I,
WDATA_I,
RDATA_O,
input wire [127:0] QUEUE_ENABLE_O);
property p(b);@(posedge CLK_SYS_I) disable iff(!RST_N_I)
CE_I&&WR_I&&ADDR_I==16'h015E-b/8|=>QUEUE_ENABLE_O[b+:16]==$past(WDATA_I);
endproperty
a_map_q112:assert property(p(112))else $error("map");
a_map_q96:assert property(p(96))else $error("map");
a_map_q80:assert property(p(80))else $error("map");
a_map_q64:assert property(p(64))else $error("map");
a_map_q48:assert property(p(48))else $error("map");
a_map_q32:assert property(p(32))else $error("map");
a_map_q16:assert property(p(16))else $error("map");
a_map_q0:assert property(p(0))else $error("map");
a_rdata_idle:assert property(@(posedge CLK_SYS_I) disable iff(!RST_N_I)
$past(CE_I)&&!$past(RD_I)|->RDATA_O==16'h0)else $error("read data not idle");
a_freeze_hold:assert property(@(posedge CLK_SYS_I) disable iff(!RST_N_I)
!CE_I|=>$stable(QUEUE_ENABLE_O)&&$stable(RDATA_O))
else $error("state moved with enable low");
endmodule

// *** tb_master_queue_enable_bank.sv ***
`timescale 1ns/1ps
module tb_master_queue_enable_bank;
reg clk=0,rst_n=0,w=0,r=0,ce=1,h;
reg [15:0] a=0,d=0;
reg [127:0] m=0;
wire [15:0] q;
wire [127:0] v;
integer error_cnt=0,n_compared=0,i;
master_queue_enable_bank DUT(.CLK_SYS_I(clk),.RST_N_I(rst_n),.CE_I(ce),
.ADDR_I(a),.WDATA_I(d),.WR_I(w),.RD_I(r),.RDATA_O(q),.QUEUE_ENABLE_O(v));
task test_done;begin
$display("%0d of %0d",error_cnt,n_compared);
if(!error_cnt&&n_compared)$display("TEST PASSED");
else $display("TEST FAILED");
$finish;
end endtask
task acc(input x,input c,input [15:0] k,dt);begin
@(posedge clk);
w<=x;r<=!x;a<=k;d<=dt;ce<=c;
@(posedge clk);
w<=0;r<=0;ce<=1;#1;
h=k[15:4]==12'h015&&!k[0];
if(x&&h&&c)m[(16'h015E-k)*8+:16]=dt;
n_compared=n_compared+1;
if({q,v}!=={!x&&h&&c?m[(16'h015E-k)*8+:16]:16'h0,m})begin
error_cnt=error_cnt+1;
$display("Error %0t bad",$time);
end
end endtask
initial forever #2 clk=~clk;
initial begin #4000;error_cnt=error_cnt+1;test_done;end
initial begin
i=$urandom(33201);
repeat(4)@(posedge clk);
rst_n<=1;
for(i=0;i<32;i=i+1)
acc(!i[0],1,16'h0150+{i[3:1],1'b0},16'($urandom));
acc(1,1,16'h0160,16'hFFFF);
acc(1,0,16'h0152,16'($urandom));
acc(0,0,16'h0152,16'h0);
acc(0,1,16'h0153,16'h0);
acc(1,1,16'h0157,16'hFFFF);
acc(0,1,16'h0156,16'h0);
acc(0,1,16'h0160,16'h0);
@(posedge clk);
rst_n<=0;
@(posedge clk);
rst_n<=1;
m=0;
acc(0,1,16'h015E,16'h0);
acc(0,1,16'h0152,16'h0);
test_done;
end
endmodule
bind master_queue_enable_bank mqe_chk chk(.*);
